// [scp_div_if.sv]
// Interface between prescaler control and the clock divider core
`timescale 1ns/1ps
interface scp_div_if;
	logic [3:0] code;
	logic tick;
	logic clk_level;
	modport ctrl (output code, input tick, input clk_level);
	modport core (input code, output tick, output clk_level);
endinterface

// [scp_divider.sv]
// Power-of-two divider producing the system clock enable and level
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_divider (
	input wire logic ref_clk,
	input wire logic reset,
	scp_div_if.core div
);
	import scp_pkg::*;

	logic [7:0] cnt;
	logic [7:0] next_cnt;
	scp_code_t active_code;
	scp_code_t next_active_code;
	logic tick;
	logic next_tick;
	logic lvl;
	logic next_lvl;

	function automatic logic [7:0] period_last(input scp_code_t c);
		logic [8:0] p;
		p = 9'h001 << c;
		period_last = 8'(p - 9'h001);
	endfunction

	// ---------------------------------------------
	// Counter, code is only adopted at period end
	// ---------------------------------------------
	always_comb begin
		next_cnt = cnt + 8'h01;
		next_active_code = active_code;
		next_tick = 1'b0;
		next_lvl = lvl;
		if (cnt >= period_last(active_code)) begin
			// Switching only at a boundary keeps every pulse whole
			next_cnt = 8'h00;
			next_tick = 1'b1;
			next_active_code = div.code;
		end
		// High for the first half of each period; ratio 1 stays high
		if (active_code == 4'h0) begin
			next_lvl = 1'b1;
		end else if (cnt >= period_last(active_code)) begin
			next_lvl = 1'b1;
		end else if (cnt == (period_last(active_code) >> 1)) begin
			next_lvl = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt <= 8'h00;
			active_code <= `SCP_CODE_RESET_PLAIN;
			tick <= 1'b0;
			lvl <= 1'b1;
		end else begin
			cnt <= next_cnt;
			active_code <= next_active_code;
			tick <= next_tick;
			lvl <= next_lvl;
		end
	end

	assign div.tick = tick;
	assign div.clk_level = lvl;
endmodule

// [scp_pkg.sv]
// Types shared by the system clock prescaler modules
package scp_pkg;
	typedef logic [3:0] scp_code_t;
	typedef logic [7:0] scp_byte_t;
	typedef enum logic [1:0] {
		SCP_LOCKED,
		SCP_UNLOCKED
	} scp_lock_state_t;
endpackage

// [scp_prescaler.sv]
// System clock prescaler: control register, unlock timer and divider
`timescale 1ns/1ps
`include "scp_regs.svh"
// How it works
// - Apart from the fuse load after reset, the select code takes a new value only while the unlock bit is set.
// - A write setting the unlock bit counts only if all other bits are zero.
// - Unlock clears four cycles after being set, or when the code is written.
// - Rewriting unlock during its timeout neither restarts nor clears it.
// - Code n divides the source clock by 2**n for 0..8; 9 and up reserved.
// - The ratio may change at run time and the divided clock feeds all.
// - Reset loads code 0; the first clock after release loads 3 with the divide-eight fuse set, else 0.
// - Software may write any code 0..8 whatever the fuse says.
module scp_prescaler (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reset_divide_eight_fuse,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire scp_pkg::scp_byte_t reg_wdata,
	output scp_pkg::scp_byte_t reg_rdata,
	output logic sys_clk_en,
	output logic sys_clk_level,
	output logic divider_change_unlock,
	output scp_pkg::scp_code_t divider_select_code
);
	import scp_pkg::*;

	scp_div_if div ();

	scp_lock_state_t state;
	scp_lock_state_t next_state;
	logic [2:0] unlock_cnt;
	logic [2:0] next_unlock_cnt;
	logic unlock_flag;
	logic next_unlock_flag;
	scp_code_t code;
	scp_code_t next_code;
	logic fuse_pending;
	logic next_fuse_pending;
	scp_byte_t rdata;
	scp_byte_t next_rdata;
	logic clk_en_q;
	logic next_clk_en_q;
	logic clk_lvl_q;
	logic next_clk_lvl_q;

	logic hit_wr;
	logic hit_rd;
	logic unlock_req;
	logic code_wr;

	// ---------------------------------------------
	// Decode helpers
	// ---------------------------------------------
	function automatic logic is_ctrl_addr(input logic [7:0] a);
		is_ctrl_addr = (a == `SCP_CTRL_ADDR);
	endfunction

	function automatic logic is_legal_code(input scp_code_t c);
		is_legal_code = (c <= `SCP_CODE_MAX);
	endfunction

	function automatic scp_code_t fuse_code(input logic f);
		fuse_code = f ? `SCP_CODE_RESET_FUSE : `SCP_CODE_RESET_PLAIN;
	endfunction

	// Same layout read back whether the window is open or not
	function automatic scp_byte_t read_image(input logic u,
		input scp_code_t c);
		read_image = 8'h00;
		read_image[`SCP_UNLOCK_BIT] = u;
		read_image[`SCP_CODE_MSB:`SCP_CODE_LSB] = c;
	endfunction

	// ---------------------------------------------
	// Register bus decode
	// ---------------------------------------------
	assign hit_wr = reg_wr && is_ctrl_addr(reg_addr);
	assign hit_rd = reg_rd && is_ctrl_addr(reg_addr);
	// Setting unlock needs the rest of the byte written as zero
	assign unlock_req = hit_wr && reg_wdata[`SCP_UNLOCK_BIT] &&
		((reg_wdata & `SCP_OTHER_BITS_MASK) == 8'h00);
	// Every other write to the register counts as a code write
	assign code_wr = hit_wr && !unlock_req;

	// ---------------------------------------------
	// Unlock window
	// ---------------------------------------------
	always_comb begin
		next_state = state;
		next_unlock_cnt = unlock_cnt;
		case (state)
			SCP_LOCKED: begin
				if (unlock_req) begin
					next_state = SCP_UNLOCKED;
					next_unlock_cnt = `SCP_UNLOCK_CYCLES;
				end
			end
			SCP_UNLOCKED: begin
				// A rewrite of unlock falls through, count not reloaded and keeps running down
				if (code_wr) begin
					next_state = SCP_LOCKED;
					next_unlock_cnt = 3'h0;
				end else if (unlock_cnt == 3'h1) begin
					next_state = SCP_LOCKED;
					next_unlock_cnt = 3'h0;
				end else begin
					next_unlock_cnt = unlock_cnt - 3'h1;
				end
			end
			default: begin
				next_state = SCP_LOCKED;
				next_unlock_cnt = 3'h0;
			end
		endcase
		// Own flop so the status pin carries no decode
		next_unlock_flag = (next_state == SCP_UNLOCKED);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= SCP_LOCKED;
			unlock_cnt <= 3'h0;
			unlock_flag <= 1'b0;
		end else begin
			state <= next_state;
			unlock_cnt <= next_unlock_cnt;
			unlock_flag <= next_unlock_flag;
		end
	end

	// ---------------------------------------------
	// Divider select code
	// ---------------------------------------------
	always_comb begin
		next_code = code;
		next_fuse_pending = 1'b0;
		// Strap caught on the first clock after reset release
		if (fuse_pending) begin
			next_code = fuse_code(reset_divide_eight_fuse);
		end
		// Taken only inside the window
		if ((state == SCP_UNLOCKED) && code_wr) begin
			// Reserved codes ignored so ratio stays 1..256
			if (is_legal_code(reg_wdata[`SCP_CODE_MSB:`SCP_CODE_LSB])) begin
				next_code = reg_wdata[`SCP_CODE_MSB:`SCP_CODE_LSB];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			code <= `SCP_CODE_RESET_PLAIN;
			fuse_pending <= 1'b1;
		end else begin
			code <= next_code;
			fuse_pending <= next_fuse_pending;
		end
	end

	// ---------------------------------------------
	// Read port
	// ---------------------------------------------
	always_comb begin
		next_rdata = rdata;
		if (hit_rd) begin
			next_rdata = read_image(unlock_flag, code);
		end else if (reg_rd) begin
			// Unmapped addresses read as zero
			next_rdata = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ---------------------------------------------
	// Divider
	// ---------------------------------------------
	assign div.code = code;

	scp_divider u_div (
		.ref_clk(ref_clk),
		.reset(reset),
		.div(div)
	);

	// ---------------------------------------------
	// System clock output stage
	// ---------------------------------------------
	// Retimed so the top-level outputs leave straight from flops
	always_comb begin
		next_clk_en_q = div.tick;
		next_clk_lvl_q = div.clk_level;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clk_en_q <= 1'b0;
			clk_lvl_q <= 1'b1;
		end else begin
			clk_en_q <= next_clk_en_q;
			clk_lvl_q <= next_clk_lvl_q;
		end
	end

	// ---------------------------------------------
	// Top-level outputs
	// ---------------------------------------------
	assign reg_rdata = rdata;
	assign sys_clk_en = clk_en_q;
	assign sys_clk_level = clk_lvl_q;
	assign divider_change_unlock = unlock_flag;
	assign divider_select_code = code;
endmodule

// [scp_prescaler_monitor.sv]
// Checker for the prescaler control register and unlock window
`timescale 1ns/1ps
module scp_prescaler_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reset_divide_eight_fuse,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire scp_pkg::scp_byte_t reg_wdata,
	input wire logic divider_change_unlock,
	input wire scp_pkg::scp_code_t divider_select_code
);
	import scp_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire wr = reg_wr && reg_addr == 8'h61;
	wire u = divider_change_unlock;
	wire [3:0] c = divider_select_code;
	sequence open_four;
		!u ##1 u[*4];
	endsequence
	chk_unlock_set: assert property (
		wr && reg_wdata == 8'h80 && !u |=> u) else $error("unlock not set");
	chk_unlock_junk: assert property (
		wr && reg_wdata[7] && reg_wdata[6:0] != 0 && !u |=> !u)
		else $error("unlock set by dirty write");
	chk_unlock_end: assert property (
		open_four |=> !u) else $error("unlock window not four cycles");
	chk_code_hold: assert property (
		!u && !$past(reset) && !$past(reset, 2) |=> $stable(c))
		else $error("code changed while locked");
	chk_code_take: assert property (
		u && wr && reg_wdata[7:4] == 0 && reg_wdata[3:0] <= 4'h8
		|=> c == $past(reg_wdata[3:0])) else $error("code not taken");
	chk_code_closes: assert property (
		u && wr && !reg_wdata[7] |=> !u) else $error("window not closed");
	chk_code_reserved: assert property (
		u && wr && reg_wdata[7:4] == 0 && reg_wdata[3:0] > 4'h8
		|=> $stable(c)) else $error("reserved code taken");
	chk_fuse_load: assert property (
		$fell(reset) |-> ##2 c == (reset_divide_eight_fuse ? 4'h3 : 4'h0))
		else $error("wrong reset code");
endmodule
bind scp_prescaler scp_prescaler_monitor mon (.ref_clk, .reset,
	.reset_divide_eight_fuse, .reg_addr, .reg_wr, .reg_wdata,
	.divider_change_unlock, .divider_select_code);

// [scp_regs.svh]
// Register map and timing constants for the system clock prescaler
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_CTRL_ADDR 8'h61
`define SCP_UNLOCK_BIT 7
`define SCP_CODE_MSB 3
`define SCP_CODE_LSB 0
`define SCP_CODE_RESET_FUSE 4'h3
`define SCP_CODE_RESET_PLAIN 4'h0
`define SCP_CODE_MAX 4'h8
`define SCP_UNLOCK_CYCLES 3'h4
`define SCP_OTHER_BITS_MASK 8'h7f

`endif

// [test_system_clock_prescaler.sv]
// Self-checking bench for the system clock prescaler
`timescale 1ns/1ps
module test_system_clock_prescaler;
	import scp_pkg::*;
	logic ref_clk = 0, reset = 1, fuse = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0;
	scp_byte_t reg_wdata = 0, reg_rdata;
	logic sys_clk_en, sys_clk_level, unlock;
	scp_code_t code;
	int num_errors = 0, cmp_count = 0, code_m, n;
	scp_prescaler dut (.ref_clk(ref_clk), .reset(reset),
		.reset_divide_eight_fuse(fuse), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sys_clk_en(sys_clk_en),
		.sys_clk_level(sys_clk_level), .divider_change_unlock(unlock),
		.divider_select_code(code));
	initial forever #10 ref_clk = ~ref_clk;
	task complete_run;
		$display("Mismatches %0d, compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input string nm, input logic [8:0] s, e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task w(input logic [7:0] a, d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge ref_clk);
		reg_wr = 0;
	endtask
	task r(input logic [7:0] a, e);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1;
		@(negedge ref_clk);
		reg_rd = 0;
		check("rdata", reg_rdata, e);
	endtask
	task rst(input logic f);
		fuse = f;
		reset = 1;
		repeat (4) @(negedge ref_clk);
		reset = 0;
		repeat (2) @(negedge ref_clk);
		code_m = f ? 3 : 0;
		check("code", code, code_m);
	endtask
	// Bounded: a dead divider must not hang the run
	task wait_en;
		n = 0;
		while (sys_clk_en !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > 600) begin
				num_errors++;
				complete_run;
			end
		end
	endtask
	initial begin
		n = $urandom(32'h9a29);
		rst(1);
		w(8'h61, 8'($urandom) & 8'h0f);
		check("code", code, code_m);
		w(8'h61, 8'h81);
		check("unlock", unlock, 0);
		r(8'h61, 8'h03);
		r(8'h20, 8'h00);
		w(8'h61, 8'h80);
		w(8'h61, 8'h80);
		check("unlock", unlock, 1);
		@(negedge ref_clk);
		check("unlock", unlock, 1);
		@(negedge ref_clk);
		check("unlock", unlock, 0);
		for (int c = 0; c < 16; c++) begin
			w(8'h61, 8'h80);
			w(8'h61, 8'(c));
			if (c < 9)
				code_m = c;
			check("code", code, code_m);
			check("unlock", unlock, 0);
			r(8'h61, 8'(code_m));
			// The old period may still run; let the new code take over
			repeat (2) @(negedge ref_clk);
			wait_en;
			@(negedge ref_clk);
			wait_en;
			check("period", 9'(n + 1), 9'(1 << code_m));
			@(negedge ref_clk);
			wait_en;
			check("period", 9'(n + 1), 9'(1 << code_m));
			check("level", sys_clk_level, 1);
			repeat ((1 << code_m) / 2) @(negedge ref_clk);
			check("level", sys_clk_level, code_m == 0);
		end
		rst(0);
		complete_run;
	end
endmodule
